// ---- include/class_code_pkg.sv ----
// Purpose: constants for the syndrome class code encoder
// Assumes: one clock pclk at 200 MHz, asynchronous active-low presetn
// Notes: register byte offsets are word aligned on the APB
//
// How it works
// - hypervisor call in 64-bit state, not disabled, gives class 0x16.
// - monitor call in 64-bit state, not disabled, gives class 0x17.
// - trapped system register access gives 0x18 unless reported as 0x00, 0x01 or 0x07.
// - vector access trapped by level 1/2/3 controls gives 0x19 unless 0x00; feature gated.
// - transaction begin with its level's enable at zero gives 0x1b; feature gated.
// - level 0 checks level-1 or level-2 user enable; levels 1-3 check their own.
// - pointer authentication failure gives 0x1c when that feature exists.
// - matrix trap or illegal streaming/storage state gives 0x1d unless 0x00.
// - granule protection check fault gives 0x1e when realm feature exists.
// - implementation-defined exception to top level gives 0x1f.
// - instruction abort from a lower level gives 0x20.
// - instruction abort at the same level gives 0x21.
// - aborts cover fetch translation and external errors, never debug causes.
// - reserved codes above 0x2c are never produced; flagged if requested.
// - length bit is one for 32-bit traps and all instruction aborts.
package class_code_pkg;
    localparam logic [5:0] CLS_UNKNOWN = 6'h00;
    localparam logic [5:0] CLS_HVC64 = 6'h16;
    localparam logic [5:0] CLS_MON64 = 6'h17;
    localparam logic [5:0] CLS_SYSREG = 6'h18;
    localparam logic [5:0] CLS_VECTOR = 6'h19;
    localparam logic [5:0] CLS_TXN = 6'h1b;
    localparam logic [5:0] CLS_PAC_FAIL = 6'h1c;
    localparam logic [5:0] CLS_MATRIX = 6'h1d;
    localparam logic [5:0] CLS_GPC = 6'h1e;
    localparam logic [5:0] CLS_IMPDEF = 6'h1f;
    localparam logic [5:0] CLS_IABT_LOW = 6'h20;
    localparam logic [5:0] CLS_IABT_SAME = 6'h21;
    localparam logic [5:0] CLS_SYNC_RSV_MAX = 6'h2c;
    // cause indices
    localparam int CAUSE_N = 11;
    localparam int C_HVC = 0;
    localparam int C_MON = 1;
    localparam int C_SYSREG = 2;
    localparam int C_VECTOR = 3;
    localparam int C_TXN = 4;
    localparam int C_PAC = 5;
    localparam int C_MATRIX = 6;
    localparam int C_GPC = 7;
    localparam int C_IMPDEF = 8;
    localparam int C_IABT = 9;
    localparam int C_DEBUG = 10;
    // apb register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_SYNDROME = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_COUNT = 8'h0c;
    // ctrl fields
    localparam int CTRL_HVC_DIS = 0;
    localparam int CTRL_MON_DIS = 1;
    localparam int CTRL_FEAT_VEC = 2;
    localparam int CTRL_FEAT_TXN = 3;
    localparam int CTRL_FEAT_PAC = 4;
    localparam int CTRL_FEAT_MAT = 5;
    localparam int CTRL_FEAT_RLM = 6;
    localparam logic [31:0] CTRL_RESET = 32'h0000007c;
    localparam logic [31:0] CTRL_MASK = 32'h0000007f;
    // syndrome fields
    localparam int SYN_IL_POS = 25;
    localparam int SYN_CLS_LSB = 26;
    localparam logic [31:0] ZERO32 = 32'h00000000;
endpackage : class_code_pkg

// ---- hw/txn_gate.sv ----
// Purpose: decide whether a transaction begin traps at the current level
// Assumes: enables are registered state on pclk
// Notes: registered output, one cycle of latency
`timescale 1ns/10ps
`default_nettype none
module txn_gate
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // level and enables
    input wire logic [1:0] priv_lvl,
    input wire logic in_lvl2_host,
    input wire logic lvl1_ctl_txn_enable_user,
    input wire logic lvl2_ctl_txn_enable_user,
    input wire logic lvl1_txn_enable,
    input wire logic lvl2_txn_enable,
    input wire logic lvl3_txn_enable,
    // result
    output logic txn_trap_ff
);
    logic nxt_txn_trap;

    // per-level enable check
    // level selects enable
    always_comb
    begin
        case (priv_lvl)
            2'h0: nxt_txn_trap = in_lvl2_host ? !lvl2_ctl_txn_enable_user : !lvl1_ctl_txn_enable_user;
            2'h1: nxt_txn_trap = !lvl1_txn_enable;
            2'h2: nxt_txn_trap = !lvl2_txn_enable;
            2'h3: nxt_txn_trap = !lvl3_txn_enable;
            default: nxt_txn_trap = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            txn_trap_ff <= 1'b0;
        else
            txn_trap_ff <= nxt_txn_trap;
    end

    property p_lvl3;
        @(posedge pclk) disable iff (!presetn)
        (priv_lvl == 2'h3) |=> (txn_trap_ff == !$past(lvl3_txn_enable));
    endproperty
    a_lvl3: assert property (p_lvl3) else $error("level 3 trap mismatch");
endmodule : txn_gate
`default_nettype wire

// ---- hw/class_encoder.sv ----
// Purpose: pick the syndrome class code and length bit for a taken exception
// Assumes: APB slave, zero wait states; exception inputs are same-clock pulses
// Notes: cause is sampled one cycle, code registered on the next
`timescale 1ns/10ps
`default_nettype none
module class_encoder
(
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // exception event from the core
    input wire logic exc_take,
    input wire logic [10:0] exc_cause,
    input wire logic exc_low_to_high,
    input wire logic exc_instr32,
    input wire logic exc_prior_low,
    // transaction context
    input wire logic [1:0] priv_lvl,
    input wire logic in_lvl2_host,
    input wire logic lvl1_ctl_txn_enable_user,
    input wire logic lvl2_ctl_txn_enable_user,
    input wire logic lvl1_txn_enable,
    input wire logic lvl2_txn_enable,
    input wire logic lvl3_txn_enable,
    // syndrome result
    output logic [5:0] syndrome_class_code,
    output logic instr_length_bit,
    output logic syndrome_valid
);
    logic [31:0] ctrl_ff;
    logic [5:0] class_ff;
    logic il_ff;
    logic valid_ff;
    logic rsv_ff;
    logic [15:0] count_ff;
    logic stage_ff;
    logic [10:0] cause_ff;
    logic low_ff;
    logic i32_ff;
    logic prior_ff;
    logic txn_trap_ff;
    logic [5:0] nxt_class;
    logic nxt_il;
    logic nxt_rsv;
    logic [31:0] nxt_prdata;
    logic wr_en;
    localparam int CAUSE_N_W = class_code_pkg::CAUSE_N;
    logic [CAUSE_N_W-1:0] hit;

    assign wr_en = psel && penable && pwrite;

    // transaction level gate, aligned with the captured cause
    txn_gate u_txn_gate
    (
        .pclk(pclk),
        .presetn(presetn),
        .priv_lvl(priv_lvl),
        .in_lvl2_host(in_lvl2_host),
        .lvl1_ctl_txn_enable_user(lvl1_ctl_txn_enable_user),
        .lvl2_ctl_txn_enable_user(lvl2_ctl_txn_enable_user),
        .lvl1_txn_enable(lvl1_txn_enable),
        .lvl2_txn_enable(lvl2_txn_enable),
        .lvl3_txn_enable(lvl3_txn_enable),
        .txn_trap_ff(txn_trap_ff)
    );

    // capture stage
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stage_ff <= 1'b0;
            cause_ff <= 11'h000;
            low_ff <= 1'b0;
            i32_ff <= 1'b0;
            prior_ff <= 1'b0;
        end
        else
        begin
            stage_ff <= exc_take;
            if (exc_take)
            begin
                cause_ff <= exc_cause;
                low_ff <= exc_low_to_high;
                i32_ff <= exc_instr32;
                prior_ff <= exc_prior_low;
            end
        end
    end

    // one-hot qualification of each cause
    genvar g;
    generate
        for (g = 0; g < CAUSE_N_W; g++)
        begin : g_hit
            assign hit[g] = cause_ff[g];
        end
    endgenerate

    // priority pick; prior_low means a lower code (0x00/0x01/0x07) already claims it
    always_comb
    begin
        nxt_class = class_code_pkg::CLS_UNKNOWN;
        nxt_il = i32_ff;
        nxt_rsv = 1'b0;
        if (hit[class_code_pkg::C_DEBUG])
            nxt_class = class_code_pkg::CLS_UNKNOWN;
        else if (hit[class_code_pkg::C_IABT] && low_ff)
            nxt_class = class_code_pkg::CLS_IABT_LOW;
        else if (hit[class_code_pkg::C_IABT])
            nxt_class = class_code_pkg::CLS_IABT_SAME;
        else if (hit[class_code_pkg::C_HVC] && !ctrl_ff[class_code_pkg::CTRL_HVC_DIS])
            nxt_class = class_code_pkg::CLS_HVC64;
        else if (hit[class_code_pkg::C_MON] && !ctrl_ff[class_code_pkg::CTRL_MON_DIS])
            nxt_class = class_code_pkg::CLS_MON64;
        else if (hit[class_code_pkg::C_SYSREG] && !prior_ff)
            nxt_class = class_code_pkg::CLS_SYSREG;
        else if (hit[class_code_pkg::C_VECTOR] && !prior_ff && ctrl_ff[class_code_pkg::CTRL_FEAT_VEC])
            nxt_class = class_code_pkg::CLS_VECTOR;
        else if (hit[class_code_pkg::C_TXN] && txn_trap_ff && ctrl_ff[class_code_pkg::CTRL_FEAT_TXN])
            nxt_class = class_code_pkg::CLS_TXN;
        else if (hit[class_code_pkg::C_PAC] && ctrl_ff[class_code_pkg::CTRL_FEAT_PAC])
            nxt_class = class_code_pkg::CLS_PAC_FAIL;
        else if (hit[class_code_pkg::C_MATRIX] && !prior_ff && ctrl_ff[class_code_pkg::CTRL_FEAT_MAT])
            nxt_class = class_code_pkg::CLS_MATRIX;
        else if (hit[class_code_pkg::C_GPC] && ctrl_ff[class_code_pkg::CTRL_FEAT_RLM])
            nxt_class = class_code_pkg::CLS_GPC;
        else if (hit[class_code_pkg::C_IMPDEF])
            nxt_class = class_code_pkg::CLS_IMPDEF;
        // length bit forced for aborts and unknown class
        if (nxt_class == class_code_pkg::CLS_IABT_LOW || nxt_class == class_code_pkg::CLS_IABT_SAME
            || nxt_class == class_code_pkg::CLS_UNKNOWN)
            nxt_il = 1'b1;
        // flag a code that would be reserved
        if (nxt_class > class_code_pkg::CLS_SYNC_RSV_MAX)
            nxt_rsv = 1'b1;
    end

    // result register, one write per exception
    // single write per exception
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            class_ff <= class_code_pkg::CLS_UNKNOWN;
            il_ff <= 1'b0;
            valid_ff <= 1'b0;
            rsv_ff <= 1'b0;
        end
        else
        begin
            valid_ff <= stage_ff;
            if (stage_ff)
            begin
                class_ff <= nxt_class;
                il_ff <= nxt_il;
                rsv_ff <= nxt_rsv;
            end
        end
    end

    // exception counter, software clear by writing, set wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            count_ff <= 16'h0000;
        else if (stage_ff)
            count_ff <= count_ff + 16'h0001;
        else if (wr_en && paddr == class_code_pkg::REG_COUNT)
            count_ff <= 16'h0000;
    end

    // control register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_ff <= class_code_pkg::CTRL_RESET;
        else if (wr_en && paddr == class_code_pkg::REG_CTRL)
            ctrl_ff <= pwdata & class_code_pkg::CTRL_MASK;
    end

    // read mux
    always_comb
    begin
        case (paddr)
            class_code_pkg::REG_CTRL: nxt_prdata = ctrl_ff;
            class_code_pkg::REG_SYNDROME: nxt_prdata = {class_ff, il_ff, 25'h0000000};
            class_code_pkg::REG_STATUS: nxt_prdata = {30'h00000000, rsv_ff, valid_ff};
            class_code_pkg::REG_COUNT: nxt_prdata = {16'h0000, count_ff};
            default: nxt_prdata = class_code_pkg::ZERO32;
        endcase
    end

    // apb answer, registered: ready in the first access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end
        else
        begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && (paddr[1:0] != 2'h0 || paddr > class_code_pkg::REG_COUNT);
            if (psel && !penable && !pwrite)
                prdata <= nxt_prdata;
        end
    end

    // outputs straight from flops
    assign syndrome_class_code = class_ff;
    assign instr_length_bit = il_ff;
    assign syndrome_valid = valid_ff;

    sequence s_abort_low;
        exc_take && exc_cause[class_code_pkg::C_IABT] && !exc_cause[class_code_pkg::C_DEBUG] && exc_low_to_high;
    endsequence
    sequence s_abort_same;
        exc_take && exc_cause[class_code_pkg::C_IABT] && !exc_cause[class_code_pkg::C_DEBUG] && !exc_low_to_high;
    endsequence

    // transaction begin seen with the feature present; gate answers one edge later
    sequence s_txn_begin;
        exc_take && exc_cause == 11'h010 && ctrl_ff[class_code_pkg::CTRL_FEAT_TXN];
    endsequence

    property p_iabt_low;
        @(posedge pclk) disable iff (!presetn)
        s_abort_low |-> ##2 (syndrome_class_code == 6'h20 && instr_length_bit);
    endproperty
    a_iabt_low: assert property (p_iabt_low) else $error("lower abort class wrong");
    property p_iabt_same;
        @(posedge pclk) disable iff (!presetn)
        s_abort_same |-> ##2 (syndrome_class_code == 6'h21 && instr_length_bit);
    endproperty
    a_iabt_same: assert property (p_iabt_same) else $error("same level abort class wrong");
    property p_hvc;
        @(posedge pclk) disable iff (!presetn)
        (exc_take && exc_cause == 11'h001 && !ctrl_ff[0]) |-> ##2 (syndrome_class_code == 6'h16);
    endproperty
    a_hvc: assert property (p_hvc) else $error("hypervisor call class wrong");
    property p_mon;
        @(posedge pclk) disable iff (!presetn)
        (exc_take && exc_cause == 11'h002 && !ctrl_ff[1]) |-> ##2 (syndrome_class_code == 6'h17);
    endproperty
    a_mon: assert property (p_mon) else $error("monitor call class wrong");
    property p_sysreg;
        @(posedge pclk) disable iff (!presetn)
        (exc_take && exc_cause == 11'h004) |-> ##2 (syndrome_class_code == ($past(exc_prior_low, 2) ? 6'h00 : 6'h18));
    endproperty
    a_sysreg: assert property (p_sysreg) else $error("system register class wrong");
    property p_vector;
        @(posedge pclk) disable iff (!presetn)
        (exc_take && exc_cause == 11'h008 && !exc_prior_low && ctrl_ff[class_code_pkg::CTRL_FEAT_VEC])
        |-> ##2 (syndrome_class_code == 6'h19);
    endproperty
    a_vector: assert property (p_vector) else $error("vector class wrong");
    property p_txn;
        @(posedge pclk) disable iff (!presetn)
        s_txn_begin ##1 txn_trap_ff |=> (syndrome_class_code == 6'h1b);
    endproperty
    a_txn: assert property (p_txn) else $error("transaction begin class wrong");
    property p_txn_clear;
        @(posedge pclk) disable iff (!presetn)
        s_txn_begin ##1 !txn_trap_ff |=> (syndrome_class_code == 6'h00);
    endproperty
    a_txn_clear: assert property (p_txn_clear) else $error("enabled transaction begin trapped");
    property p_pac;
        @(posedge pclk) disable iff (!presetn)
        (exc_take && exc_cause == 11'h020 && ctrl_ff[4]) |-> ##2 (syndrome_class_code == 6'h1c);
    endproperty
    a_pac: assert property (p_pac) else $error("authentication class wrong");
    property p_matrix;
        @(posedge pclk) disable iff (!presetn)
        (exc_take && exc_cause == 11'h040 && !exc_prior_low && ctrl_ff[class_code_pkg::CTRL_FEAT_MAT])
        |-> ##2 (syndrome_class_code == 6'h1d);
    endproperty
    a_matrix: assert property (p_matrix) else $error("matrix class wrong");
    property p_gpc;
        @(posedge pclk) disable iff (!presetn)
        (exc_take && exc_cause == 11'h080 && ctrl_ff[class_code_pkg::CTRL_FEAT_RLM])
        |-> ##2 (syndrome_class_code == 6'h1e);
    endproperty
    a_gpc: assert property (p_gpc) else $error("granule protection class wrong");
    property p_impdef;
        @(posedge pclk) disable iff (!presetn)
        (exc_take && exc_cause == 11'h100) |-> ##2 (syndrome_class_code == 6'h1f);
    endproperty
    a_impdef: assert property (p_impdef) else $error("impdef class wrong");
    property p_debug;
        @(posedge pclk) disable iff (!presetn)
        (exc_take && exc_cause[10]) |-> ##2 (syndrome_class_code == 6'h00);
    endproperty
    a_debug: assert property (p_debug) else $error("debug reported as abort");
    property p_il_trap;
        @(posedge pclk) disable iff (!presetn)
        (exc_take && exc_cause == 11'h004 && !exc_prior_low) |-> ##2 (instr_length_bit == $past(exc_instr32, 2));
    endproperty
    a_il_trap: assert property (p_il_trap) else $error("trap length bit wrong");
    property p_one;
        @(posedge pclk) disable iff (!presetn)
        syndrome_valid == $past(exc_take, 2);
    endproperty
    a_one: assert property (p_one) else $error("code write count wrong");
    property p_rsv;
        @(posedge pclk) disable iff (!presetn)
        syndrome_valid |-> syndrome_class_code <= 6'h2c;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved class produced");
endmodule : class_encoder
`default_nettype wire

// ---- verif/tb_exception_class_syndrome_encoder.sv ----
// Purpose: self-checking bench for the syndrome class code encoder
// Assumes: zero-wait APB slave, class code two edges after the exception is taken
// Notes: transaction context is set one cycle ahead since its gate is registered
`timescale 1ns/10ps
`default_nettype none
module tb_exception_class_syndrome_encoder;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic exc_take, exc_low_to_high, exc_instr32, exc_prior_low, er;
    logic [10:0] exc_cause;
    logic [1:0] priv_lvl;
    logic in_lvl2_host, u1, u2, e1, e2, e3;
    logic [5:0] syndrome_class_code;
    logic instr_length_bit, syndrome_valid;
    logic [5:0] cls_tab [0:8];
    logic [8:0] txn_tab [0:8];
    int fails, comparisons, pulses;

    class_encoder dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .exc_take(exc_take), .exc_cause(exc_cause), .exc_low_to_high(exc_low_to_high),
        .exc_instr32(exc_instr32), .exc_prior_low(exc_prior_low), .priv_lvl(priv_lvl),
        .in_lvl2_host(in_lvl2_host), .lvl1_ctl_txn_enable_user(u1), .lvl2_ctl_txn_enable_user(u2),
        .lvl1_txn_enable(e1), .lvl2_txn_enable(e2), .lvl3_txn_enable(e3),
        .syndrome_class_code(syndrome_class_code), .instr_length_bit(instr_length_bit),
        .syndrome_valid(syndrome_valid));

    // 200 MHz clock
    always #2.5 pclk = ~pclk;

    task automatic end_of_test;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // one apb transfer; held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 16)
        begin
            @(posedge pclk);
            n++;
        end
        if (n >= 16)
        begin
            fails++;
            end_of_test();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // one taken exception; any_ok only checks that no abort class appears
    task automatic exc(input logic [10:0] cause, input logic low, input logic i32, input logic [5:0] ecls,
                       input logic eil, input logic any_ok);
        int n;
        n = 0;
        @(posedge pclk);
        exc_take <= 1'b1;
        exc_cause <= cause;
        exc_low_to_high <= low;
        exc_instr32 <= i32;
        @(posedge pclk);
        exc_take <= 1'b0;
        @(posedge pclk);
        while (syndrome_valid !== 1'b1 && n < 8)
        begin
            @(posedge pclk);
            n++;
        end
        if (n >= 8)
        begin
            fails++;
            end_of_test();
        end
        if (any_ok)
            chk({31'h0, syndrome_class_code[5:1] === 5'h10}, 32'h0);
        else
        begin
            chk({26'h0, syndrome_class_code}, {26'h0, ecls});
            chk({31'h0, instr_length_bit}, {31'h0, eil});
        end
    endtask : exc

    initial
    begin
        pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
        pwdata = 32'h0; exc_take = 1'b0; exc_cause = 11'h000; exc_low_to_high = 1'b0;
        exc_instr32 = 1'b1; exc_prior_low = 1'b0; priv_lvl = 2'h1; in_lvl2_host = 1'b0;
        {u1, u2, e1, e2, e3} = 5'h13;
        fails = 0; comparisons = 0;
        cls_tab = '{6'h16, 6'h17, 6'h18, 6'h19, 6'h1b, 6'h1c, 6'h1d, 6'h1e, 6'h1f};
        // {trap, level, host, u1, u2, e1, e2, e3}
        txn_tab = '{9'h10f, 9'h017, 9'h137, 9'h02f, 9'h15b, 9'h05d, 9'h19d, 9'h1de, 9'h0c1};
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        chk({26'h0, syndrome_class_code}, 32'h0);
        apb(1'b0, class_code_pkg::REG_CTRL, 32'h0);
        chk(rd, class_code_pkg::CTRL_RESET);
        // every cause with all features present; txn traps at level 1
        for (int i = 0; i < 9; i++)
            exc(11'(1 << i), 1'b0, 1'b1, cls_tab[i], 1'b1, 1'b0);
        exc(11'h200, 1'b1, 1'b0, 6'h20, 1'b1, 1'b0);
        exc(11'h200, 1'b0, 1'b0, 6'h21, 1'b1, 1'b0);
        exc(11'h004, 1'b0, 1'b0, 6'h18, 1'b0, 1'b0);
        exc_prior_low <= 1'b1;
        exc(11'h004, 1'b0, 1'b1, 6'h00, 1'b1, 1'b0);
        exc_prior_low <= 1'b0;
        exc(11'h600, 1'b1, 1'b1, 6'h00, 1'b1, 1'b1);
        // transaction begin enables by level
        for (int i = 0; i < 9; i++)
        begin
            {priv_lvl, in_lvl2_host, u1, u2, e1, e2, e3} <= txn_tab[i][7:0];
            exc(11'h010, 1'b0, 1'b1, txn_tab[i][8] ? 6'h1b : 6'h00, 1'b1, 1'b0);
        end
        {priv_lvl, in_lvl2_host, u1, u2, e1, e2, e3} <= 8'h5b;
        // calls disabled and every feature absent
        apb(1'b1, class_code_pkg::REG_CTRL, 32'h00000003);
        apb(1'b0, class_code_pkg::REG_CTRL, 32'h0);
        chk(rd, 32'h00000003);
        for (int i = 0; i < 8; i++)
            exc(11'(1 << i), 1'b0, 1'b1, (i == 2) ? 6'h18 : 6'h00, 1'b1, 1'b0);
        apb(1'b1, class_code_pkg::REG_CTRL, 32'h0000007c);
        exc(11'h100, 1'b0, 1'b1, 6'h1f, 1'b1, 1'b0);
        apb(1'b0, class_code_pkg::REG_SYNDROME, 32'h0);
        chk(rd & 32'hfe000000, 32'h7e000000);
        // back to back exceptions, one code each
        apb(1'b1, class_code_pkg::REG_COUNT, 32'h0);
        @(posedge pclk);
        exc_take <= 1'b1;
        exc_cause <= 11'h100;
        @(posedge pclk);
        exc_cause <= 11'h200;
        exc_low_to_high <= 1'b1;
        @(posedge pclk);
        exc_take <= 1'b0;
        pulses = 0;
        repeat (6)
        begin
            @(posedge pclk);
            if (syndrome_valid === 1'b1)
                pulses++;
        end
        chk(32'(pulses), 32'h2);
        chk({26'h0, syndrome_class_code}, 32'h20);
        apb(1'b0, class_code_pkg::REG_COUNT, 32'h0);
        chk(rd & 32'h0000ffff, 32'h2);
        apb(1'b0, class_code_pkg::REG_STATUS, 32'h0);
        chk(rd, 32'h0);
        // unmapped address is refused
        apb(1'b0, 8'h10, 32'h0);
        chk({31'h0, er}, 32'h1);
        chk(rd, 32'h0);
        end_of_test();
    end
endmodule : tb_exception_class_syndrome_encoder
`default_nettype wire
